// ---- dv/embedded_ss_device.sv ----
// model of the embedded superspeed device on a split power pin
`timescale 1ns/1ps
module embedded_ss_device (
  input  wire       clk,   // core clock
  input  wire       power, // supply, 1 = on
  input  wire       hang,  // keep training stuck
  output reg  [3:0] state  // link state seen by hub
);
  reg [4:0] up = 5'h00;
  initial state = 4'h5;
  // unpowered shows rx detect; powered trains to u0 after 20 cycles
  always @(posedge clk) begin
    if (!power) begin
      up <= 5'h00;
      state <= 4'h5;
    end else if (hang) begin
      state <= 4'h7;
    end else if (up != 5'd20) begin
      up <= up + 5'd1;
      state <= 4'h7;
    end else begin
      state <= 4'h0;
    end
  end
endmodule // embedded_ss_device

// ---- dv/port_split_link_watchdog_bench.sv ----
// self-checking bench for the split power link watchdog
`timescale 1ns/1ps
module port_split_link_watchdog_bench;
  reg        clk = 1'b0, sys_rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, otp = 1'b0;
  reg        p3 = 1'b0, p4 = 1'b0, hang = 1'b0;
  reg [15:0] addr = 16'h0000;
  reg [7:0]  wd = 8'h00, otp_v = 8'h00;
  reg [7:0]  code [0:3];
  reg [3:0]  fo = 4'h0, foe = 4'h0;
  reg [15:0] n = 16'h0000;
  wire [3:0] ls3, ls4, po, poe;
  wire [7:0] rdata;
  wire       ctl3, ctl4, ss3, ss4;
  wire [1:0] ss = {ss4, ss3};
  integer    err_count = 0, compares = 0, cyc = 0, i;
  always #5 clk = ~clk;
  // ten clocks per millisecond keeps stuck-link runs short
  port_split_link_watchdog #(.MS_CYCLES(10)) dut (.clk(clk), .sys_rst(sys_rst),
    .cfg_wr(wr_s), .cfg_rd(rd_s),
    .cfg_addr(addr), .cfg_wdata(wd), .cfg_rdata(rdata), .otp_load(otp), .otp_timeout(otp_v),
    .port3_link_train_state_status(ls3), .port4_link_train_state_status(ls4),
    .port3_power_req(p3), .port4_power_req(p4), .gpio_func_out(fo), .gpio_func_oe(foe),
    .port3_power_ctl_pin(ctl3), .port4_power_ctl_pin(ctl4),
    .port3_option_a_pin_o(po[0]), .port3_option_a_pin_oe(poe[0]),
    .port3_option_b_pin_o(po[1]), .port3_option_b_pin_oe(poe[1]),
    .port4_option_a_pin_o(po[2]), .port4_option_a_pin_oe(poe[2]),
    .port4_option_b_pin_o(po[3]), .port4_option_b_pin_oe(poe[3]),
    .port3_superspeed_power_pin(ss3), .port4_superspeed_power_pin(ss4));
  embedded_ss_device dev3 (.clk(clk), .power(ss3), .hang(hang), .state(ls3));
  embedded_ss_device dev4 (.clk(clk), .power(ss4), .hang(hang), .state(ls4));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr_s <= 1'b0;
    end
  endtask
  // read holds one cycle; data lands on the taking edge
  task rdc(input [15:0] a, input [7:0] e);
    begin
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(rdata, e);
    end
  endtask
  task t_reset;
    begin
      rdc(16'h3c48, 8'h00);
      rdc(16'h416e, 8'h00);
      rdc(16'h416f, 8'h00);
      rdc(16'h4171, 8'h05);
      rdc(16'h4176, 8'h05);
      rdc(16'h1234, 8'h00);
      $display("test reset values done");
    end
  endtask
  task t_regs;
    begin
      wr(16'h3c48, 8'h1e);
      repeat (4) @(posedge clk);
      #1 chk(ss, 2'b00);
      wr(16'h3c48, 8'hff);
      rdc(16'h3c48, 8'hfe);
      wr(16'h4171, 8'hff);
      rdc(16'h4171, 8'h07);
      wr(16'h4176, 8'hff);
      rdc(16'h4176, 8'hff);
      wr(16'h1234, 8'h5a);
      rdc(16'h1234, 8'h00);
      @(posedge clk);
      otp <= 1'b1;
      otp_v <= 8'hfb;
      wr_s <= 1'b1;
      addr <= 16'h4171;
      wd <= 8'h01;
      @(posedge clk);
      otp <= 1'b0;
      wr_s <= 1'b0;
      rdc(16'h4171, 8'h03);
      wr(16'h3c48, 8'h00);
      $display("test registers done");
    end
  endtask
  task t_ctl;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge clk);
        p3 <= i[0];
        p4 <= i[1];
        fo <= 4'h3 << i;
        foe <= 4'hc >> i;
        @(posedge clk);
        #1 chk({ctl4, ctl3}, i[1:0]);
        chk({poe, po}, {4'hc >> i, 4'h3 << i});
      end
      $display("test power and pins done");
    end
  endtask
  task t_route;
    begin
      @(posedge clk);
      fo <= 4'h0;
      foe <= 4'hf;
      for (i = 0; i < 4; i = i + 1) begin
        wr(i < 2 ? 16'h416e : 16'h416f, code[i]);
        wr(16'h3c48, i < 2 ? 8'h20 : 8'h40);
        repeat (30) @(posedge clk);
        #1 chk(ss, 2'h1 << (i / 2));
        chk({poe, po}, {4'hf, 4'h1 << i});
        @(posedge clk);
        p3 <= ~p3;
        @(posedge clk);
        #1 chk(ctl3, p3);
        wr(16'h3c48, 8'h00);
        repeat (4) @(posedge clk);
        #1 chk({ss, po}, 6'h00);
      end
      wr(16'h416e, 8'h33);
      wr(16'h3c48, 8'h20);
      repeat (4) @(posedge clk);
      #1 chk({ss, po}, {2'b01, 4'h0});
      $display("test pin routing done");
    end
  endtask
  // cycles until ss3 leaves level lv, bounded by lim
  task wait_ss3(input lv, input [15:0] lim);
    begin
      n = 16'h0000;
      while (ss3 === lv && n < lim) begin
        @(posedge clk);
        #1 n = n + 16'd1;
      end
    end
  endtask
  task t_stuck;
    begin
      wr(16'h4171, 8'h01);
      wr(16'h4176, 8'h00);
      wr(16'h416e, 8'h42);
      @(posedge clk);
      hang <= 1'b1;
      #1 wait_ss3(1'b1, 16'd2000);
      chk({15'h0000, n >= 16'd990 && n <= 16'd1010}, 16'h0001);
      chk({ss3, po[0]}, 2'b00);
      wait_ss3(1'b0, 16'd5000);
      chk(n, 16'd3500);
      wait_ss3(1'b1, 16'd2000);
      chk(n, 16'd1000);
      wr(16'h4171, 8'h00);
      wait_ss3(1'b0, 16'd5000);
      chk({15'h0000, n >= 16'd3490 && n <= 16'd3500}, 16'h0001);
      wait_ss3(1'b1, 16'd1500);
      chk(n, 16'd1500);
      $display("test short stuck done");
    end
  endtask
  task t_rerun;
    begin
      @(posedge clk);
      sys_rst <= 1'b1;
      hang <= 1'b0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      #1 chk({6'h00, ss, po, poe}, 16'h0000);
      rdc(16'h3c48, 8'h00);
      rdc(16'h4171, 8'h05);
      rdc(16'h416e, 8'h00);
      $display("test mid-run reset done");
    end
  endtask
  task test_done;
    begin
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // ceiling well above the roughly eleven thousand cycles the tests need
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      test_done;
    end
  end
  initial begin
    code[0] = 8'h42;
    code[1] = 8'h05;
    code[2] = 8'h06;
    code[3] = 8'h04;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_regs;
    t_ctl;
    t_route;
    t_stuck;
    t_rerun;
    test_done;
  end
endmodule // port_split_link_watchdog_bench

// ---- dv/split_watchdog_monitor.sv ----
// port-level assertions for the split power watchdog
`timescale 1ns/1ps
module split_watchdog_monitor (
  input wire        clk, sys_rst, cfg_wr, cfg_rd, otp_load,
  input wire [15:0] cfg_addr,
  input wire [7:0]  cfg_wdata, otp_timeout,
  input wire [3:0]  gpio_func_out, gpio_func_oe,
  input wire        port3_power_req, port4_power_req,
  input wire [7:0]  cfg_rdata,
  input wire        port3_power_ctl_pin, port4_power_ctl_pin, port3_superspeed_power_pin,
  input wire        port3_option_a_pin_o, port3_option_a_pin_oe
);
  reg [7:0] en, s3;
  reg [2:0] tmo;
  wire a3 = en[5] && s3 == 8'h42;
  // mirror of the writes, so pin checks know the configuration
  always @(posedge clk) begin
    if (sys_rst) begin
      en <= 8'h00;
      s3 <= 8'h00;
      tmo <= 3'h5;
    end else begin
      if (cfg_wr && cfg_addr == 16'h3c48) en <= cfg_wdata & 8'hfe;
      if (cfg_wr && cfg_addr == 16'h416e) s3 <= cfg_wdata;
      if (otp_load) tmo <= otp_timeout[2:0];
      else if (cfg_wr && cfg_addr == 16'h4171) tmo <= cfg_wdata[2:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_ctl3_follow: assert property (!sys_rst |=> port3_power_ctl_pin == $past(port3_power_req))
    else $error("port 3 power pin lost its request");
  chk_ctl4_follow: assert property (!sys_rst |=> port4_power_ctl_pin == $past(port4_power_req))
    else $error("port 4 power pin lost its request");
  chk_ss_power_on: assert property ($rose(en[5]) |-> ##[1:3] port3_superspeed_power_pin)
    else $error("split pin not powered after enable");
  chk_ss_power_off: assert property ($fell(en[5]) |-> ##[1:3] !port3_superspeed_power_pin)
    else $error("split pin still driven after disable");
  chk_route_opt_a: assert property (a3 |-> ##[1:3] port3_option_a_pin_oe &&
    port3_option_a_pin_o == port3_superspeed_power_pin)
    else $error("option a pin not carrying split power");
  chk_pass_opt_a: assert property ((!a3) [*3] |-> port3_option_a_pin_oe == $past(gpio_func_oe[0])
    && port3_option_a_pin_o == $past(gpio_func_out[0]))
    else $error("option a pin not passing its normal function");
  chk_no_pulse_off: assert property ($fell(port3_superspeed_power_pin) && en[5] |->
    tmo != 3'h0 && tmo != 3'h7)
    else $error("split pin pulsed with timeout off");
  chk_rd_enable: assert property (cfg_rd && !cfg_wr && cfg_addr == 16'h3c48 |=> cfg_rdata == en)
    else $error("split enable read wrong");
  chk_rd_timeout: assert property (cfg_rd && !cfg_wr && !otp_load && cfg_addr == 16'h4171
    |=> cfg_rdata == {5'h00, tmo})
    else $error("timeout read wrong");
  cov_enable: cover property ($rose(en[5]));
  cov_route: cover property (a3 ##3 port3_option_a_pin_oe);
  cov_otp: cover property (otp_load ##2 cfg_rd);
  cov_pulse: cover property ($fell(port3_superspeed_power_pin) && en[5]);
endmodule // split_watchdog_monitor
bind port_split_link_watchdog split_watchdog_monitor u_mon (.clk, .sys_rst, .cfg_wr, .cfg_rd,
  .otp_load, .cfg_addr, .cfg_wdata, .otp_timeout, .gpio_func_out, .gpio_func_oe,
  .port3_power_req, .port4_power_req, .cfg_rdata, .port3_power_ctl_pin, .port4_power_ctl_pin,
  .port3_superspeed_power_pin, .port3_option_a_pin_o, .port3_option_a_pin_oe);

// ---- hw/port_split_link_watchdog.v ----
// register file, pin routing and watchdogs for ports 3 and 4 split power
`timescale 1ns/1ps
`include "port_split_regs.vh"
module port_split_link_watchdog #(
  parameter MS_CYCLES = `MS_TICK_CYCLES // core clocks per millisecond tick
) (
  input  wire        clk,             // core clock 100 MHz
  input  wire        sys_rst,         // sync reset, active high
  input  wire        cfg_wr,          // register write strobe
  input  wire        cfg_rd,          // register read strobe
  input  wire [15:0] cfg_addr,        // register address
  input  wire [7:0]  cfg_wdata,       // write data
  output reg  [7:0]  cfg_rdata,       // read data, valid cycle after read
  input  wire        otp_load,        // OTP override strobe
  input  wire [7:0]  otp_timeout,     // OTP timeout value
  input  wire [3:0]  port3_link_train_state_status, // port 3 link state
  input  wire [3:0]  port4_link_train_state_status, // port 4 link state
  input  wire        port3_power_req, // hub port 3 power request
  input  wire        port4_power_req, // hub port 4 power request
  input  wire [3:0]  gpio_func_out,   // normal gpio output: a3,b3,a4,b4
  input  wire [3:0]  gpio_func_oe,    // normal gpio enable
  output reg         port3_power_ctl_pin, // port 3 2.0 power
  output reg         port4_power_ctl_pin, // port 4 2.0 power
  output reg         port3_option_a_pin_o,  // pin output
  output reg         port3_option_a_pin_oe, // pin enable
  output reg         port3_option_b_pin_o,  // pin output
  output reg         port3_option_b_pin_oe, // pin enable
  output reg         port4_option_a_pin_o,  // pin output
  output reg         port4_option_a_pin_oe, // pin enable
  output reg         port4_option_b_pin_o,  // pin output
  output reg         port4_option_b_pin_oe, // pin enable
  output reg         port3_superspeed_power_pin, // port 3 ss power level
  output reg         port4_superspeed_power_pin  // port 4 ss power level
);
  reg  [7:0]  split_enable_per_port;
  reg  [7:0]  port3_split_pin_select;
  reg  [7:0]  port4_split_pin_select;
  reg  [2:0]  stuck_link_timeout_cfg;
  reg  [7:0]  power_toggle_duration_cfg;
  reg  [16:0] ms_div;
  reg         ms_tick;
  reg  [11:0] timeout_ms;
  wire        p3_pwr;
  wire        p4_pwr;
  wire        p3_pulsing;
  wire        p4_pulsing;
  wire        p3_en;
  wire        p4_en;

  // divider end point, cut to the counter width on purpose
  localparam integer MS_LAST_FULL = MS_CYCLES - 1;
  localparam [16:0]  MS_LAST      = MS_LAST_FULL[16:0];

  // only bits 5 and 6 drive hardware
  assign p3_en = split_enable_per_port[`SPLIT_EN_P3_BIT];
  assign p4_en = split_enable_per_port[`SPLIT_EN_P4_BIT];

  // register writes; OTP override wins on the timeout register
  always @(posedge clk) begin
    if (sys_rst) begin
      split_enable_per_port     <= `RST_SPLIT_ENABLE;
      port3_split_pin_select    <= `RST_PIN_SELECT;
      port4_split_pin_select    <= `RST_PIN_SELECT;
      stuck_link_timeout_cfg    <= 3'h5;
      power_toggle_duration_cfg <= `RST_TOGGLE_CFG;
    end else begin
      if (cfg_wr) begin
        case (cfg_addr)
          `ADDR_SPLIT_ENABLE:  split_enable_per_port <= cfg_wdata & `SPLIT_EN_WMASK;
          `ADDR_P3_PIN_SELECT: port3_split_pin_select <= cfg_wdata;
          `ADDR_P4_PIN_SELECT: port4_split_pin_select <= cfg_wdata;
          `ADDR_TIMEOUT_CFG:   stuck_link_timeout_cfg <= cfg_wdata[2:0];
          `ADDR_TOGGLE_CFG:    power_toggle_duration_cfg <= cfg_wdata;
          default: ;
        endcase
      end
      if (otp_load) begin
        stuck_link_timeout_cfg <= otp_timeout[2:0];
      end
    end
  end

  // register reads; unmapped addresses read zero
  always @(posedge clk) begin
    if (sys_rst) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_addr)
        `ADDR_SPLIT_ENABLE:  cfg_rdata <= split_enable_per_port;
        `ADDR_P3_PIN_SELECT: cfg_rdata <= port3_split_pin_select;
        `ADDR_P4_PIN_SELECT: cfg_rdata <= port4_split_pin_select;
        `ADDR_TIMEOUT_CFG:   cfg_rdata <= {5'h00, stuck_link_timeout_cfg};
        `ADDR_TOGGLE_CFG:    cfg_rdata <= power_toggle_duration_cfg;
        default:             cfg_rdata <= 8'h00;
      endcase
    end
  end

  // timeout code to milliseconds; reserved code treated as off
  always @* begin
    case (stuck_link_timeout_cfg)
      3'h1:    timeout_ms = `TO_100MS;
      3'h2:    timeout_ms = `TO_250MS;
      3'h3:    timeout_ms = `TO_500MS;
      3'h4:    timeout_ms = `TO_750MS;
      3'h5:    timeout_ms = `TO_1S_MS;
      3'h6:    timeout_ms = `TO_2S_MS;
      default: timeout_ms = 12'h000;
    endcase
  end

  // millisecond enable from a single divider keeps both ports in step
  always @(posedge clk) begin
    if (sys_rst) begin
      ms_div  <= 17'h00000;
      ms_tick <= 1'b0;
    end else if (ms_div == MS_LAST) begin
      ms_div  <= 17'h00000;
      ms_tick <= 1'b1;
    end else begin
      ms_div  <= ms_div + 17'd1;
      ms_tick <= 1'b0;
    end
  end

  split_port_watchdog u_wd3 (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .ms_tick      (ms_tick),
    .split_en     (p3_en),
    .link_state   (port3_link_train_state_status),
    .timeout_ms   (timeout_ms),
    .toggle_field (power_toggle_duration_cfg),
    .pin_power    (p3_pwr),
    .pulsing      (p3_pulsing)
  );

  split_port_watchdog u_wd4 (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .ms_tick      (ms_tick),
    .split_en     (p4_en),
    .link_state   (port4_link_train_state_status),
    .timeout_ms   (timeout_ms),
    .toggle_field (power_toggle_duration_cfg),
    .pin_power    (p4_pwr),
    .pulsing      (p4_pulsing)
  );

  // pin routing; no overcurrent input exists on the split path
  always @(posedge clk) begin
    if (sys_rst) begin
      port3_power_ctl_pin        <= 1'b0;
      port4_power_ctl_pin        <= 1'b0;
      port3_superspeed_power_pin <= 1'b0;
      port4_superspeed_power_pin <= 1'b0;
      port3_option_a_pin_o       <= 1'b0;
      port3_option_a_pin_oe      <= 1'b0;
      port3_option_b_pin_o       <= 1'b0;
      port3_option_b_pin_oe      <= 1'b0;
      port4_option_a_pin_o       <= 1'b0;
      port4_option_a_pin_oe      <= 1'b0;
      port4_option_b_pin_o       <= 1'b0;
      port4_option_b_pin_oe      <= 1'b0;
    end else begin
      port3_power_ctl_pin        <= port3_power_req;
      port4_power_ctl_pin        <= port4_power_req;
      port3_superspeed_power_pin <= p3_en & p3_pwr;
      port4_superspeed_power_pin <= p4_en & p4_pwr;
      if (p3_en && port3_split_pin_select == `P3_SEL_OPT_A) begin
        port3_option_a_pin_o  <= p3_pwr;
        port3_option_a_pin_oe <= 1'b1;
      end else begin
        port3_option_a_pin_o  <= gpio_func_out[0];
        port3_option_a_pin_oe <= gpio_func_oe[0];
      end
      if (p3_en && port3_split_pin_select == `P3_SEL_OPT_B) begin
        port3_option_b_pin_o  <= p3_pwr;
        port3_option_b_pin_oe <= 1'b1;
      end else begin
        port3_option_b_pin_o  <= gpio_func_out[1];
        port3_option_b_pin_oe <= gpio_func_oe[1];
      end
      if (p4_en && port4_split_pin_select == `P4_SEL_OPT_A) begin
        port4_option_a_pin_o  <= p4_pwr;
        port4_option_a_pin_oe <= 1'b1;
      end else begin
        port4_option_a_pin_o  <= gpio_func_out[2];
        port4_option_a_pin_oe <= gpio_func_oe[2];
      end
      if (p4_en && port4_split_pin_select == `P4_SEL_OPT_B) begin
        port4_option_b_pin_o  <= p4_pwr;
        port4_option_b_pin_oe <= 1'b1;
      end else begin
        port4_option_b_pin_o  <= gpio_func_out[3];
        port4_option_b_pin_oe <= gpio_func_oe[3];
      end
    end
  end
endmodule // port_split_link_watchdog

// ---- hw/port_split_regs.vh ----
// constants for the port split link watchdog: offsets, fields, resets, timing
`ifndef PORT_SPLIT_REGS_VH
`define PORT_SPLIT_REGS_VH
`define ADDR_SPLIT_ENABLE     16'h3c48
`define ADDR_P3_PIN_SELECT    16'h416e
`define ADDR_P4_PIN_SELECT    16'h416f
`define ADDR_TIMEOUT_CFG      16'h4171
`define ADDR_TOGGLE_CFG       16'h4176
`define SPLIT_EN_P3_BIT       5
`define SPLIT_EN_P4_BIT       6
`define SPLIT_EN_WMASK        8'hfe
`define RST_SPLIT_ENABLE      8'h00
`define RST_PIN_SELECT        8'h00
`define RST_TIMEOUT_CFG       8'h05
`define RST_TOGGLE_CFG        8'h05
`define P3_SEL_OPT_A          8'h42
`define P3_SEL_OPT_B          8'h05
`define P4_SEL_OPT_A          8'h06
`define P4_SEL_OPT_B          8'h04
`define STUCK_STATE_LO        4'h4
`define STUCK_STATE_HI        4'h9
`define CLK_HZ                100000000
`define MS_TICK_CYCLES        (`CLK_HZ / 1000)
`define TOGGLE_BASE_MS        12'd350
`define TOGGLE_STEP_MS        12'd10
`define TO_100MS              12'd100
`define TO_250MS              12'd250
`define TO_500MS              12'd500
`define TO_750MS              12'd750
`define TO_1S_MS              12'd1000
`define TO_2S_MS              12'd2000
`endif

// ---- hw/split_port_watchdog.v ----
// per-port stuck-link watchdog and split power pulse generator
`timescale 1ns/1ps
`include "port_split_regs.vh"
module split_port_watchdog (
  input  wire        clk,          // core clock
  input  wire        sys_rst,      // sync reset, active high
  input  wire        ms_tick,      // one-cycle pulse per millisecond
  input  wire        split_en,     // splitting enabled on this port
  input  wire [3:0]  link_state,   // link training state, same clock
  input  wire [11:0] timeout_ms,   // stuck timeout in ms, zero = off
  input  wire [7:0]  toggle_field, // pulse length field
  output reg         pin_power,    // superspeed power level, 1 = on
  output reg         pulsing       // pulse in progress
);
  reg [11:0] to_cnt;
  reg [11:0] pulse_cnt;
  reg [3:0]  last_state;
  wire       stuck_code;
  wire [11:0] pulse_len;

  assign stuck_code = (link_state >= `STUCK_STATE_LO) && (link_state <= `STUCK_STATE_HI);
  assign pulse_len  = `TOGGLE_BASE_MS + ({4'h0, toggle_field} * `TOGGLE_STEP_MS);

  // a state change or a valid link restarts the interval
  always @(posedge clk) begin
    if (sys_rst || !split_en) begin
      to_cnt     <= 12'h000;
      pulse_cnt  <= 12'h000;
      pulsing    <= 1'b0;
      pin_power  <= 1'b1;
      last_state <= 4'h0;
    end else if (pulsing) begin
      if (ms_tick) begin
        if (pulse_cnt + 12'd1 >= pulse_len) begin
          pulse_cnt <= 12'h000;
          pulsing   <= 1'b0;
          pin_power <= 1'b1;
          to_cnt    <= 12'h000;
        end else begin
          pulse_cnt <= pulse_cnt + 12'd1;
        end
      end
    end else begin
      last_state <= link_state;
      if (!stuck_code || link_state != last_state || timeout_ms == 12'h000) begin
        to_cnt <= 12'h000;
      end else if (ms_tick) begin
        if (to_cnt + 12'd1 >= timeout_ms) begin
          to_cnt    <= 12'h000;
          pulsing   <= 1'b1;
          pin_power <= 1'b0;
        end else begin
          to_cnt <= to_cnt + 12'd1;
        end
      end
    end
  end
endmodule // split_port_watchdog
